// ==== shared/sfcp_defs.svh ====
// constants for the serial flash command front end
`ifndef SFCP_DEFS_SVH
`define SFCP_DEFS_SVH
`define SFCP_OP_WREN 8'h06
`define SFCP_OP_VWREN 8'h50
`define SFCP_OP_WRDI 8'h04
`define SFCP_OP_RDSR1 8'h05
`define SFCP_OP_RDSR2 8'h35
`define SFCP_OP_WRSR 8'h01
`define SFCP_OP_PP 8'h02
`define SFCP_OP_QPP 8'h32
`define SFCP_OP_SE4 8'h20
`define SFCP_OP_BE32 8'h52
`define SFCP_OP_BE64 8'hD8
`define SFCP_OP_CE1 8'hC7
`define SFCP_OP_CE2 8'h60
`define SFCP_OP_SUSP 8'h75
`define SFCP_OP_RESM 8'h7A
`define SFCP_OP_PDN 8'hB9
`define SFCP_OP_READ 8'h03
`define SFCP_OP_FREAD 8'h0B
`define SFCP_OP_DREAD 8'h3B
`define SFCP_OP_QREAD 8'h6B
`define SFCP_OP_RDID 8'hAB
`define SFCP_OP_MDID 8'h90
`define SFCP_OP_MDID2 8'h92
`define SFCP_OP_MDID4 8'h94
`define SFCP_OP_JDID 8'h9F
`define SFCP_ADDR_TOP 24'h0FFFFF
`define SFCP_ADDR_MASK 24'h0FFFFF
`define SFCP_SZ_4K 24'h001000
`define SFCP_SZ_8K 24'h002000
`define SFCP_SZ_16K 24'h004000
`define SFCP_SZ_32K 24'h008000
`define SFCP_SZ_64K 24'h010000
`define SFCP_SZ_128K 24'h020000
`define SFCP_SZ_256K 24'h040000
`define SFCP_SZ_512K 24'h080000
// status bit positions within the 16-bit status word
`define SFCP_ST_WEL 1
`define SFCP_ST_BP0 2
`define SFCP_ST_TB 5
`define SFCP_ST_SEC 6
`define SFCP_ST_QE 9
`define SFCP_ST_CMP 14
`define SFCP_ST_SUS 15
`define SFCP_ST_RESET 16'h4000
`define SFCP_ST_WMASK 16'h7FFC
`define SFCP_BUSY_CYCLES 16'h0040
`endif

// ==== shared/sfcp_pkg.sv ====
// types for the serial flash command front end
package sfcp_pkg;
	typedef enum logic [2:0] {
		SFCP_PH_OP = 3'b000,
		SFCP_PH_ADDR = 3'b001,
		SFCP_PH_DUMMY = 3'b010,
		SFCP_PH_DATA = 3'b011,
		SFCP_PH_OUT = 3'b100,
		SFCP_PH_IDLE = 3'b101
	} sfcp_phase_e;
	typedef enum logic [1:0] {
		SFCP_LN_1 = 2'b00,
		SFCP_LN_2 = 2'b01,
		SFCP_LN_4 = 2'b10
	} sfcp_lanes_e;
endpackage

// ==== src/sfcp_protect.sv ====
// protected-range decode for the complement protection map
`timescale 1ns/1ns
`include "sfcp_defs.svh"
module sfcp_protect (
	// status fields
	input wire logic cmp,
	input wire logic sec,
	input wire logic tb,
	input wire logic [2:0] bp,
	// range under test, inclusive
	input wire logic [23:0] lo,
	input wire logic [23:0] hi,
	// result
	output logic hit
);
	logic [23:0] plo;
	logic [23:0] phi;
	logic pnone;
	logic [23:0] ulen;
	always_comb begin
		plo = 24'h000000;
		phi = `SFCP_ADDR_TOP;
		pnone = 1'b0;
		ulen = 24'h000000;
		if (!cmp || bp == 3'b000) begin
			// complement off is out of scope here; treat all-clear bp as all
			pnone = cmp ? 1'b0 : 1'b1; // [RULE1]
		end else if (bp == 3'b111) begin
			pnone = 1'b1; // [RULE2]
		end else if (!sec) begin
			case (bp)
				3'b001: ulen = `SFCP_SZ_64K;
				3'b010: ulen = `SFCP_SZ_128K;
				3'b011: ulen = `SFCP_SZ_256K;
				3'b100: ulen = `SFCP_SZ_512K;
				default: ulen = 24'h000000;
			endcase
			if (ulen == 24'h000000) begin
				pnone = 1'b0;
			end else if (!tb) begin
				phi = `SFCP_ADDR_TOP - ulen; // [RULE2]
			end else begin
				plo = ulen; // [RULE3]
			end
		end else begin
			case (bp)
				3'b001: ulen = `SFCP_SZ_4K; // [RULE4]
				3'b010: ulen = `SFCP_SZ_8K;
				3'b011: ulen = `SFCP_SZ_16K;
				default: ulen = `SFCP_SZ_32K; // [RULE5]
			endcase
			if (!tb) begin
				phi = `SFCP_ADDR_TOP - ulen;
			end else begin
				plo = ulen;
			end
		end
	end
	assign hit = !pnone && (lo <= phi) && (hi >= plo); // [RULE6]
endmodule

// ==== src/sfcp_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/1ns
module sfcp_sync #(
	parameter int WIDTH = 1
) (
	// clock
	input wire logic clk,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge clk) begin
		meta <= d;
		q <= meta;
	end
endmodule

// ==== src/sfcp_top.sv ====
// serial flash instruction front end with complement block protection
// What this block does
// RULE1: cmp set and bp 000 protects whole 1 MB array.
// RULE2: sec 0 tb 0: bp 001..100 protect lower 15/16..1/2; 111 none.
// RULE3: sec 0 tb 1: same codes protect upper parts from 64K..512K.
// RULE4: sec 1: bp 001..011 leave 4/8/16 KB open, top or bottom.
// RULE5: sec 1: bp 10x or 110 leave 32 KB open, top or bottom.
// RULE6: erase or program touching protected area is ignored.
// RULE7: chip select fall starts instruction; first byte is opcode.
// RULE8: input sampled on rising link clock, msb first.
// RULE9: chip select rise completes the instruction.
// RULE10: reads may end after any bit.
// RULE11: writes, programs, erases need whole bytes else ignored.
// RULE12: while busy and not suspended only status reads and 75 are honoured.
// RULE13: id opcodes 90/92/94/9F return maker and device codes, AB device only; 9F gives 16-bit device.
// RULE14: 06 sets, 04 clears write enable, 50 volatile; 01 takes two bytes.
// RULE15: status reads repeat the byte until chip select rises.
// RULE16: 02,20,52,D8 take 24-bit address; C7/60 none.
// RULE17: quad program takes each byte as two nibbles on four lines.
// RULE18: 03 data follows address; 0B has one dummy byte.
// RULE19: 3B single-line address and dummy, then two bits per clock.
// RULE20: 6B single-line address and dummy, then four bits per clock.
// RULE21: 75 suspends, 7A resumes, B9 powers down; no further bytes.
// RULE22: host sends FF FF to leave continuous read mode.
// RULE23: write enable needed before program, erase or status write.
// RULE24: lines 2 and 3 carry data only while quad enable is 1.
// RULE25: unknown opcodes ignored, outputs stay undriven.
// RULE26: protection checked on the system clock when the captured instruction executes, before array cycle.
`timescale 1ns/1ns
`include "sfcp_defs.svh"
module sfcp_top #(
	parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h5A, // arbitrary value
	parameter logic [15:0] JEDEC_DEV = 16'h3C3C, // arbitrary value
	parameter logic [15:0] BUSY_CYCLES = `SFCP_BUSY_CYCLES
) (
	// system clock domain
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// link pins, link clock domain
	input wire logic link_clk,
	input wire logic cs_n,
	input wire logic [3:0] line_in,
	output logic [3:0] line_out,
	output logic [3:0] line_oe,
	// array side, system domain
	output logic [7:0] read_opcode,
	output logic [23:0] op_addr,
	output logic [7:0] op_code,
	output logic op_start,
	output logic busy,
	output logic suspended,
	output logic powered_down,
	output logic [15:0] status,
	input wire logic [7:0] array_rdata
);
	//////////////////////////////////////////////////////////////////
	// link domain: shifter and decode
	sfcp_pkg::sfcp_phase_e ph;
	sfcp_pkg::sfcp_lanes_e out_ln;
	logic [7:0] op;
	logic [7:0] sh;
	logic [5:0] bits;
	logic [2:0] nbyte;
	logic [23:0] addr;
	logic [7:0] dat0;
	logic [7:0] obyte;
	logic [2:0] obit;
	logic [15:0] st_l;
	logic busy_l;
	logic [7:0] rdata_l;
	logic serial_in;
	logic [7:0] next_sh;
	logic [7:0] done_op;
	logic [23:0] done_addr;
	logic [7:0] done_d0;
	logic done_whole;
	logic done_tgl;
	logic byte_done;
	logic quad_in;
	assign serial_in = line_in[0];
	assign quad_in = (op == `SFCP_OP_QPP) && st_l[`SFCP_ST_QE]; // [RULE17] [RULE24]
	always_comb begin
		if (quad_in && ph == sfcp_pkg::SFCP_PH_DATA) begin
			next_sh = {sh[3:0], line_in}; // [RULE17]
		end else begin
			next_sh = {sh[6:0], serial_in}; // [RULE8]
		end
	end
	assign byte_done = quad_in && ph == sfcp_pkg::SFCP_PH_DATA ?
		(bits[0] == 1'b1) : (bits[2:0] == 3'b111);
	// cs_n high acts as reset of the link logic; clock stops outside frames
	always_ff @(posedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			ph <= sfcp_pkg::SFCP_PH_OP; // [RULE7]
			bits <= 6'h00;
			nbyte <= 3'h0;
			sh <= 8'h00;
			op <= 8'h00;
			addr <= 24'h000000;
			dat0 <= 8'h00;
		end else begin
			sh <= next_sh;
			bits <= bits + 6'h01;
			if (byte_done) begin
				nbyte <= nbyte + 3'h1;
				case (ph)
					sfcp_pkg::SFCP_PH_OP: begin
						op <= next_sh; // [RULE7]
						case (next_sh)
							`SFCP_OP_PP, `SFCP_OP_QPP, `SFCP_OP_SE4, `SFCP_OP_BE32,
							`SFCP_OP_BE64, `SFCP_OP_READ, `SFCP_OP_FREAD,
							`SFCP_OP_DREAD, `SFCP_OP_QREAD, `SFCP_OP_MDID:
								ph <= sfcp_pkg::SFCP_PH_ADDR; // [RULE16]
							`SFCP_OP_WRSR: ph <= sfcp_pkg::SFCP_PH_DATA; // [RULE14]
							`SFCP_OP_RDSR1, `SFCP_OP_RDSR2, `SFCP_OP_JDID,
							`SFCP_OP_RDID, `SFCP_OP_MDID2, `SFCP_OP_MDID4:
								ph <= sfcp_pkg::SFCP_PH_OUT;
							default: ph <= sfcp_pkg::SFCP_PH_IDLE; // [RULE21] [RULE25]
						endcase
					end
					sfcp_pkg::SFCP_PH_ADDR: begin
						addr <= {addr[15:0], next_sh};
						if (nbyte == 3'h3) begin
							if (op == `SFCP_OP_FREAD || op == `SFCP_OP_DREAD ||
								op == `SFCP_OP_QREAD) begin
								ph <= sfcp_pkg::SFCP_PH_DUMMY; // [RULE18]
							end else if (op == `SFCP_OP_PP || op == `SFCP_OP_QPP) begin
								ph <= sfcp_pkg::SFCP_PH_DATA;
							end else if (op == `SFCP_OP_READ || op == `SFCP_OP_MDID) begin
								ph <= sfcp_pkg::SFCP_PH_OUT; // [RULE18]
							end else begin
								ph <= sfcp_pkg::SFCP_PH_IDLE;
							end
						end
					end
					sfcp_pkg::SFCP_PH_DUMMY: ph <= sfcp_pkg::SFCP_PH_OUT;
					sfcp_pkg::SFCP_PH_DATA: begin
						if (nbyte == 3'h1 || op != `SFCP_OP_WRSR) begin
							dat0 <= next_sh;
						end else begin
							addr[7:0] <= next_sh; // second status byte [RULE14]
						end
					end
					default: ph <= ph;
				endcase
			end
		end
	end
	// output lane width per read opcode
	always_comb begin
		if (op == `SFCP_OP_DREAD) begin
			out_ln = sfcp_pkg::SFCP_LN_2; // [RULE19]
		end else if (op == `SFCP_OP_QREAD && st_l[`SFCP_ST_QE]) begin
			out_ln = sfcp_pkg::SFCP_LN_4; // [RULE20] [RULE24]
		end else begin
			out_ln = sfcp_pkg::SFCP_LN_1;
		end
	end
	// output byte selection
	always_comb begin
		case (op)
			`SFCP_OP_RDSR1: obyte = st_l[7:0]; // [RULE15]
			`SFCP_OP_RDSR2: obyte = st_l[15:8];
			`SFCP_OP_RDID: obyte = DEV_ID; // [RULE13]
			`SFCP_OP_MDID, `SFCP_OP_MDID2, `SFCP_OP_MDID4:
				obyte = nbyte[0] ? DEV_ID : MAKER_ID;
			`SFCP_OP_JDID: obyte = nbyte == 3'h1 ? MAKER_ID :
				(nbyte == 3'h2 ? JEDEC_DEV[15:8] : JEDEC_DEV[7:0]);
			default: obyte = rdata_l;
		endcase
	end
	// outputs shift on the falling link edge
	always_ff @(negedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			line_out <= 4'h0;
			line_oe <= 4'h0; // [RULE25]
			obit <= 3'h7;
		end else if (ph == sfcp_pkg::SFCP_PH_OUT && !(busy_l &&
			op != `SFCP_OP_RDSR1 && op != `SFCP_OP_RDSR2)) begin // [RULE12]
			case (out_ln)
				sfcp_pkg::SFCP_LN_2: begin
					line_out <= {2'b00, obyte[obit], obyte[obit - 3'h1]};
					line_oe <= 4'h3;
					obit <= obit - 3'h2;
				end
				sfcp_pkg::SFCP_LN_4: begin
					line_out <= obit[2] ? obyte[7:4] : obyte[3:0];
					line_oe <= 4'hF;
					obit <= obit - 3'h4;
				end
				default: begin
					line_out <= {2'b00, obyte[obit], 1'b0};
					line_oe <= 4'h2;
					obit <= obit - 3'h1;
				end
			endcase
		end
	end
	// capture completed instruction at chip select rise
	always_ff @(posedge cs_n) begin
		done_op <= op; // [RULE9]
		done_addr <= addr;
		done_d0 <= dat0;
		done_whole <= (quad_in && ph == sfcp_pkg::SFCP_PH_DATA) ? !bits[0] :
			bits[2:0] == 3'b000; // [RULE11]
	end
	// toggle must start known, else the system side never sees an edge
	always_ff @(posedge cs_n or posedge srst) begin
		if (srst) done_tgl <= 1'b0;
		else done_tgl <= !done_tgl; // [RULE9]
	end
	sfcp_sync #(.WIDTH(17)) u_sync_link (
		.clk(link_clk),
		.d({busy, status}),
		.q({busy_l, st_l})
	);
	sfcp_sync #(.WIDTH(8)) u_sync_rd (
		.clk(link_clk),
		.d(array_rdata),
		.q(rdata_l)
	);
	//////////////////////////////////////////////////////////////////
	// system domain: execute completed instructions
	logic [2:0] tgl_s;
	logic [15:0] busy_cnt;
	logic vwe;
	logic hit;
	logic [23:0] r_lo;
	logic [23:0] r_hi;
	logic [23:0] a_m;
	logic is_write;
	logic exec;
	assign a_m = done_addr & `SFCP_ADDR_MASK;
	always_comb begin
		r_lo = a_m;
		r_hi = a_m;
		case (done_op)
			`SFCP_OP_SE4: begin
				r_lo = a_m & ~(`SFCP_SZ_4K - 24'h1);
				r_hi = r_lo + `SFCP_SZ_4K - 24'h1;
			end
			`SFCP_OP_BE32: begin
				r_lo = a_m & ~(`SFCP_SZ_32K - 24'h1);
				r_hi = r_lo + `SFCP_SZ_32K - 24'h1;
			end
			`SFCP_OP_BE64: begin
				r_lo = a_m & ~(`SFCP_SZ_64K - 24'h1);
				r_hi = r_lo + `SFCP_SZ_64K - 24'h1;
			end
			`SFCP_OP_CE1, `SFCP_OP_CE2: begin
				r_lo = 24'h000000;
				r_hi = `SFCP_ADDR_TOP;
			end
			default: r_hi = {a_m[23:8], 8'hFF};
		endcase
	end
	sfcp_protect u_prot (
		.cmp(status[`SFCP_ST_CMP]),
		.sec(status[`SFCP_ST_SEC]),
		.tb(status[`SFCP_ST_TB]),
		.bp(status[`SFCP_ST_BP0 +: 3]),
		.lo(r_lo),
		.hi(r_hi),
		.hit(hit)
	);
	assign is_write = done_op == `SFCP_OP_PP || done_op == `SFCP_OP_QPP ||
		done_op == `SFCP_OP_SE4 || done_op == `SFCP_OP_BE32 ||
		done_op == `SFCP_OP_BE64 || done_op == `SFCP_OP_CE1 || done_op == `SFCP_OP_CE2;
	assign exec = tgl_s[2] != tgl_s[1];
	always_ff @(posedge clk) begin
		if (srst) begin
			tgl_s <= 3'b000;
		end else if (ce) begin
			tgl_s <= {tgl_s[1], tgl_s[0], done_tgl};
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			status <= `SFCP_ST_RESET;
			busy <= 1'b0;
			busy_cnt <= 16'h0000;
			vwe <= 1'b0;
			suspended <= 1'b0;
			powered_down <= 1'b0;
			op_start <= 1'b0;
			op_code <= 8'h00;
			op_addr <= 24'h000000;
			read_opcode <= 8'h00;
		end else if (ce) begin
			op_start <= 1'b0;
			if (busy && !suspended) begin
				if (busy_cnt == 16'h0000) begin
					busy <= 1'b0;
					status[`SFCP_ST_WEL] <= 1'b0;
				end else begin
					busy_cnt <= busy_cnt - 16'h0001;
				end
			end
			if (exec) begin
				read_opcode <= done_op; // [RULE10]
				if (busy && !suspended && done_op != `SFCP_OP_SUSP) begin
					// while busy and not suspended only suspend passes on; status reads have no effect here
				end else if (done_op == `SFCP_OP_WREN && done_whole) begin
					status[`SFCP_ST_WEL] <= 1'b1; // [RULE14]
				end else if (done_op == `SFCP_OP_WRDI && done_whole) begin
					status[`SFCP_ST_WEL] <= 1'b0;
					vwe <= 1'b0;
				end else if (done_op == `SFCP_OP_VWREN && done_whole) begin
					vwe <= 1'b1;
				end else if (done_op == `SFCP_OP_WRSR && done_whole &&
					(status[`SFCP_ST_WEL] || vwe)) begin // [RULE23]
					status <= (status & ~`SFCP_ST_WMASK) |
						({done_addr[7:0], done_d0} & `SFCP_ST_WMASK);
					vwe <= 1'b0;
					busy <= 1'b1;
					busy_cnt <= BUSY_CYCLES;
				end else if (is_write && done_whole && status[`SFCP_ST_WEL] &&
					!hit) begin // [RULE6] [RULE11] [RULE23] [RULE26]
					op_start <= 1'b1;
					op_code <= done_op;
					op_addr <= a_m;
					busy <= 1'b1;
					busy_cnt <= BUSY_CYCLES;
				end else if (done_op == `SFCP_OP_SUSP && busy) begin
					suspended <= 1'b1; // [RULE21]
					status[`SFCP_ST_SUS] <= 1'b1;
				end else if (done_op == `SFCP_OP_RESM && suspended) begin
					suspended <= 1'b0;
					status[`SFCP_ST_SUS] <= 1'b0;
				end else if (done_op == `SFCP_OP_PDN) begin
					powered_down <= 1'b1;
				end else if (done_op == `SFCP_OP_RDID) begin
					powered_down <= 1'b0;
				end
			end
		end
	end
	//////////////////////////////////////////////////////////////////
	// checks
	busy_blocks_a: assert property (@(posedge clk) disable iff (srst)
		ce && busy && !suspended && exec |=> !op_start) // [RULE12]
		else $error("instruction started while busy");
	wel_needed_a: assert property (@(posedge clk) disable iff (srst)
		op_start |-> $past(status[`SFCP_ST_WEL])) // [RULE23]
		else $error("array op without write enable");
	prot_block_a: assert property (@(posedge clk) disable iff (srst)
		ce && exec && hit && is_write |=> !op_start) // [RULE6]
		else $error("protected region operation started");
	whole_byte_a: assert property (@(posedge clk) disable iff (srst)
		ce && exec && !done_whole |=> !op_start) // [RULE11]
		else $error("partial byte write started");
	busy_set_a: assert property (@(posedge clk) disable iff (srst)
		op_start |-> busy) // [RULE26]
		else $error("start without busy");
	sus_flag_a: assert property (@(posedge clk) disable iff (srst)
		suspended == status[`SFCP_ST_SUS]) // [RULE21]
		else $error("suspend flag mismatch");
	all_prot_a: assert property (@(posedge clk)
		status[`SFCP_ST_CMP] && status[`SFCP_ST_BP0 +: 3] == 3'b000 |-> hit) // [RULE1]
		else $error("whole array not protected");
	none_prot_a: assert property (@(posedge clk)
		status[`SFCP_ST_CMP] && status[`SFCP_ST_BP0 +: 3] == 3'b111 |-> !hit) // [RULE2]
		else $error("code 111 protects something");
	start_cov: cover property (@(posedge clk) op_start);
	susp_cov: cover property (@(posedge clk) suspended);
	wrsr_cov: cover property (@(posedge clk) exec && done_op == `SFCP_OP_WRSR);
endmodule

// ==== bench/sfcp_host_model.sv ====
// host serial master model for the flash front end pins
`timescale 1ns/1ns
module sfcp_host_model (
	// link pins
	output logic link_clk,
	output logic cs_n,
	output logic [3:0] line_in,
	// device drive
	input wire logic [3:0] line_out,
	input wire logic [3:0] line_oe
);
	logic [3:0] drv;
	// a line the device drives shows the device level, else ours
	assign line_in = (line_oe & line_out) | (~line_oe & drv);
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		drv = 4'hE;
	end
	//////////////////////////////////////////////////////////////////
	// clock stands low outside frames; data set up before the rise
	task automatic tick(input logic [3:0] d, output logic [3:0] q);
		drv = d;
		#15 link_clk = 1'b1;
		q = line_in;
		#15 link_clk = 1'b0;
	endtask
	task automatic start();
		#7 cs_n = 1'b0;
		#20;
	endtask
	task automatic stop();
		#20 cs_n = 1'b1;
		drv = {2'b11, ~drv[1:0]};
		#40;
	endtask
	task automatic send8(input logic [7:0] b);
		logic [3:0] q;
		for (int i = 7; i >= 0; i--) tick({2'b11, ~drv[1], b[i]}, q);
	endtask
	task automatic send24(input logic [23:0] a);
		send8(a[23:16]);
		send8(a[15:8]);
		send8(a[7:0]);
	endtask
	task automatic send_nib(input logic [7:0] b);
		logic [3:0] q;
		tick(b[7:4], q);
		tick(b[3:0], q);
	endtask
	task automatic clocks(input int n);
		logic [3:0] q;
		repeat (n) tick({2'b11, ~drv[1:0]}, q);
	endtask
	// lanes of 1, 2 or 4; line 1 carries single-line output
	task automatic recv8(input int lanes, output logic [7:0] v);
		logic [3:0] q;
		for (int i = 0; i < 8 / lanes; i++) begin
			tick({2'b11, ~drv[1:0]}, q);
			if (lanes == 1) v = {v[6:0], q[1]};
			else if (lanes == 2) v = {v[5:0], q[1:0]};
			else v = {v[3:0], q};
		end
	endtask
endmodule

// ==== bench/tb_sfcp_top.sv ====
// self-checking bench for the serial flash command front end
`timescale 1ns/1ns
module tb_sfcp_top;
	localparam logic [7:0] MKR = 8'hC3; // arbitrary value
	localparam logic [7:0] DID = 8'h3C; // arbitrary value
	localparam logic [15:0] JDEV = 16'h7E81; // arbitrary value
	logic clk, srst, ce, link_clk, cs_n, op_start, busy, suspended, powered_down;
	logic [3:0] line_in, line_out, line_oe;
	logic [7:0] read_opcode, op_code, array_rdata, v;
	logic [23:0] op_addr, a;
	logic [15:0] status, st;
	logic [31:0] seed, r;
	int n_mismatch, checks, starts;
	logic [23:0] corner [6] = '{24'h000000, 24'h001000, 24'h007000, 24'h008000, 24'h0FE000,
		24'h0FF000};
	logic [7:0] codes [7] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
	logic [7:0] rops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
	int rln [4] = '{1, 1, 2, 4};
	sfcp_top #(.MAKER_ID(MKR), .DEV_ID(DID), .JEDEC_DEV(JDEV), .BUSY_CYCLES(16'h00C8)) dut (
		.clk(clk), .srst(srst), .ce(ce), .link_clk(link_clk), .cs_n(cs_n), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .read_opcode(read_opcode), .op_addr(op_addr),
		.op_code(op_code), .op_start(op_start), .busy(busy), .suspended(suspended),
		.powered_down(powered_down), .status(status), .array_rdata(array_rdata));
	sfcp_host_model host (.link_clk(link_clk), .cs_n(cs_n), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe));
	always #5 clk = ~clk;
	always @(posedge clk) if (op_start === 1'b1) starts <= starts + 1;
	//////////////////////////////////////////////////////////////////
	// protected-range overlap with complement protection set
	function automatic logic hit(input logic [15:0] s, input logic [23:0] lo, input logic [23:0] hi);
		logic [2:0] bp;
		logic [23:0] u, plo, phi;
		bp = s[4:2];
		if (bp == 3'b000) return 1'b1;
		if (bp == 3'b111) return 1'b0;
		if (!s[6]) u = 24'h010000 << (bp - 3'd1);
		else u = bp[2] ? 24'h008000 : 24'h001000 << (bp - 3'd1);
		plo = s[5] ? u : 24'h000000;
		phi = s[5] ? 24'h0FFFFF : 24'h0FFFFF - u;
		return (lo <= phi) && (hi >= plo);
	endfunction
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// waits out the crossing, then any busy period, under a bound
	task automatic settle();
		int n;
		repeat (6) @(posedge clk);
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
		if (n == 3000) begin
			n_mismatch++;
			$display("[FAIL] busy expected 0 seen %b", busy);
			results();
		end
		repeat (2) @(posedge clk);
	endtask
	task automatic frame(input logic [7:0] c);
		host.start();
		host.send8(c);
		host.stop();
		repeat (8) @(posedge clk);
	endtask
	task automatic op(input logic [7:0] c);
		frame(c);
		settle();
	endtask
	task automatic wrsr(input logic [15:0] w);
		op(8'h06);
		host.start();
		host.send8(8'h01);
		host.send8(w[7:0]);
		host.send8(w[15:8]);
		host.stop();
		settle();
		chk("status", {8'h0, w & 16'h7FFC}, {8'h0, status & 16'h7FFC});
	endtask
	task automatic erase(input logic [7:0] c, input logic [23:0] ad, input logic wen,
			input logic exp);
		if (wen) op(8'h06);
		starts = 0;
		host.start();
		host.send8(c);
		if (c != 8'hC7 && c != 8'h60) host.send24(ad);
		if (c == 8'h02) host.send8(8'h5A);
		if (c == 8'h32) host.send_nib(8'hA5);
		host.stop();
		settle();
		chk("op_start", {23'h0, exp}, starts[23:0]);
		if (exp) chk("op_code", {16'h0, c}, {16'h0, op_code});
		if (exp && c != 8'hC7 && c != 8'h60) chk("op_addr", ad, op_addr);
	endtask
	// reads end three clocks into the next byte, off a byte boundary
	task automatic rd(input logic [7:0] c, input int pre, input int lanes, input int nb,
			input logic [23:0] exp);
		host.start();
		host.send8(c);
		repeat (pre) host.send8(8'h00);
		for (int i = nb - 1; i >= 0; i--) begin
			host.recv8(lanes, v);
			chk("read byte", {16'h0, exp[8*i +: 8]}, {16'h0, v});
		end
		host.clocks(3);
		host.stop();
		settle();
		chk("read_opcode", {16'h0, c}, {16'h0, read_opcode});
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		srst <= 1'b1;
		ce = 1'b1;
		array_rdata = 8'h00;
		seed = 32'h8A1BE67F;
		n_mismatch = 0;
		checks = 0;
		starts = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		settle();
		chk("status", 24'h004000, {8'h0, status});
		erase(8'h20, 24'h0A0000, 1'b1, 1'b0);
		op(8'h06);
		chk("wel", 24'h1, {23'h0, status[1]});
		op(8'h04);
		chk("wel", 24'h0, {23'h0, status[1]});
		op(8'h50);
		chk("wel", 24'h0, {23'h0, status[1]});
		wrsr(16'h401C);
		erase(8'h20, 24'h000000, 1'b0, 1'b0);
		op(8'h06);
		starts = 0;
		host.start();
		host.send8(8'h20);
		host.send8(8'h00);
		host.send8(8'h00);
		host.clocks(7);
		host.stop();
		settle();
		chk("op_start", 24'h0, starts[23:0]);
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			st = {2'b01, 7'h00, r[0], r[1], r[4:2], 2'b00};
			if (!r[0] && (r[4:2] == 3'd5 || r[4:2] == 3'd6)) st[4:2] = 3'b111;
			wrsr(st);
			for (int j = 0; j < 7; j++) begin
				r = $random(seed);
				a = (j < 6) ? corner[j] : {4'h0, r[19:12], 12'h000};
				erase(8'h20, a, 1'b1, !hit(st, a, a + 24'h000FFF));
			end
		end
		st = 16'h421C;
		wrsr(st);
		foreach (codes[i]) erase(codes[i], 24'h020000, 1'b1, 1'b1);
		// an accepted erase keeps the device busy for the next frames
		op(8'h06);
		host.start();
		host.send8(8'h20);
		host.send24(24'h030000);
		host.stop();
		repeat (8) @(posedge clk);
		frame(8'h06);
		frame(8'h75);
		chk("suspended", 24'h1, {23'h0, suspended});
		frame(8'h7A);
		chk("suspended", 24'h0, {23'h0, suspended});
		settle();
		chk("wel", 24'h0, {23'h0, status[1]});
		rd(8'h05, 0, 1, 3, {3{st[7:0]}});
		rd(8'h35, 0, 1, 3, {3{st[15:8]}});
		rd(8'h9F, 0, 1, 3, {MKR, JDEV});
		rd(8'h90, 3, 1, 2, {8'h00, MKR, DID});
		rd(8'hAB, 3, 1, 2, {8'h00, DID, DID});
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			@(posedge clk) array_rdata <= r[7:0];
			rd(rops[i], (i == 0) ? 3 : 4, rln[i], 1, {16'h0, r[7:0]});
		end
		host.start();
		host.send8(8'hFF);
		host.send8(8'hFF);
		host.clocks(8);
		chk("line_oe", 24'h0, {20'h0, line_oe});
		host.stop();
		settle();
		// clock enable low holds the crossing; the command lands once it returns
		@(posedge clk) ce <= 1'b0;
		frame(8'hB9);
		repeat (20) @(posedge clk);
		chk("powered_down", 24'h0, {23'h0, powered_down});
		@(posedge clk) ce <= 1'b1;
		settle();
		chk("powered_down", 24'h1, {23'h0, powered_down});
		results();
	end
endmodule
